// [core/rtc_counter_alarm_trim.v]
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.vh"

// What this block does
// [R1] Rate bit picks 512Hz tap when set, 1Hz tap when clear, while output on.
// [R2] Square-wave enable drives the chosen tap out; clear leaves the pin undriven.
// [R3] Seconds matching 20-bit alarm sets the day-alarm flag; interrupt if enabled.
// [R4] Unmasked day alarm also requests stop-mode wakeup and switchback.
// [R5] Ready interrupt enable lets a set ready flag raise an interrupt.
// [R6] Hardware sets ready after each count update; software may clear it anytime.
// [R7] Hardware clears ready one slow clock before each count update, except one inserted by trim.
// [R8] Busy sets on reset, count writes, run and alarm enable changes; clears on next slow edge.
// [R9] Software waits for busy to clear before trusting a write or enable change.
// [R10] Sub-second alarm interrupts only while its enable is set.
// [R11] Day alarm interrupts only while its enable is set.
// [R12] Run enable gates the 256Hz tick into the counters.
// [R13] Run enable is writable only while unlock bit 15 is set.
// [R14] Time base is 8-bit sub-second counter into 32-bit seconds, two halves.
// [R15] Sub-second counts 256Hz ticks from 32.768 kHz or alternate source.
// [R16] Count registers accept writes only with run and busy both clear.
// [R17] Alarm compares low 20 bits of alarm against low 20 bits of seconds.
// [R18] Day alarm registers writable only with day enable and busy clear.
// [R19] Reload register feeds sub-second alarm timer; each reload sets its flag.
// [R20] Reload register writable only with sub-second enable and busy clear.
// [R21] Trim sign: zero inserts, one removes pulses; trim writable only when unlocked.
// [R22] Trim magnitude accumulates every 16 seconds; carry adds or removes 128 clocks.
// [R23] While busy, writes to run, alarm enables and counts are blocked.
// [R24] Carry: positive trim takes the 512Hz stage, negative masks a 256Hz pulse.
module rtc_counter_alarm_trim #(
    parameter RELOAD_W = 16,
    parameter HF_DIV_LAST = 7'h7F
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Register port
    input wire [2:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdData,
    // Slow oscillator pin
    input wire osc32kIn,
    // Square-wave pin
    output reg sqWaveOut,
    output reg sqWaveOe_n,
    // Requests to the system
    output reg irqReq,
    output reg wakeReq,
    output reg oscDisable
);

    // Pin synchroniser and accepted level
    reg oscS1_q, oscS2_q, oscS3_q, oscLvl_q;
    // Control bits
    reg unlock_q, altSrc_q, sqRate_q, sqEn_q, ssFlag_q, todFlag_q, rdyIe_q, rdy_q;
    reg busy_q, ssEn_q, todEn_q, run_q;
    // Counters and alarms
    reg [6:0] presc_q;
    reg [6:0] hfDiv_q;
    reg [7:0] subSec_q;
    reg [31:0] sec_q;
    reg [3:0] almHi_q;
    reg [15:0] almLo_q;
    reg [RELOAD_W-1:0] reload_q;
    reg [RELOAD_W-1:0] ssTimer_q;
    reg secUpd_q, cntUpd_q;
    // Trim
    reg trimDir_q;
    reg [4:0] trimMag_q;
    reg [4:0] trimAcc_q;
    reg trimPend_q;
    // Reload value as seen on the 16-bit read port
    wire [15:0] reloadRd;

    generate
        if (RELOAD_W < 16) begin : g_reloadPad
            assign reloadRd = {{(16-RELOAD_W){1'b0}}, reload_q};
        end else begin : g_reloadFull
            assign reloadRd = reload_q[15:0];
        end
    endgenerate

    wire oscRise = (oscS2_q == oscS3_q) && oscS3_q && !oscLvl_q;
    wire hfTick = (hfDiv_q == HF_DIV_LAST);
    wire srcTick = altSrc_q ? hfTick : oscRise; // [R15]
    wire stageTick = srcTick && (presc_q == `RTC_PRESC_LAST);
    wire halfTick = srcTick && (presc_q == `RTC_PRESC_HALF);
    // Trim correction on the 256Hz stage
    wire tick256 = (trimPend_q && !trimDir_q) ? (stageTick || halfTick) : // [R24]
                   (trimPend_q && trimDir_q) ? 1'b0 : stageTick; // [R24]
    wire trimUsed = trimPend_q && (trimDir_q ? stageTick : (stageTick || halfTick));
    wire cntTick = tick256 && run_q; // [R12]

    wire wrCtrl = regWr && (regAddr == `RTC_ADDR_CTRL);
    wire cntWrOk = regWr && !run_q && !busy_q; // [R16] [R23]
    wire wrSecHi = cntWrOk && (regAddr == `RTC_ADDR_SECHI);
    wire wrSecLo = cntWrOk && (regAddr == `RTC_ADDR_SECLO);
    wire wrSub = cntWrOk && (regAddr == `RTC_ADDR_SUBSEC);
    wire almWrOk = regWr && !todEn_q && !busy_q; // [R18]
    wire wrAlmHi = almWrOk && (regAddr == `RTC_ADDR_ALMHI);
    wire wrAlmLo = almWrOk && (regAddr == `RTC_ADDR_ALMLO);
    wire wrReload = regWr && !ssEn_q && !busy_q && (regAddr == `RTC_ADDR_RELOAD); // [R20]
    wire wrTrim = regWr && unlock_q && (regAddr == `RTC_ADDR_TRIM); // [R21]

    // Enable changes that are allowed now
    wire runNew = (wrCtrl && !busy_q && unlock_q) ? regWrData[`RTC_B_RUN] : run_q; // [R13] [R23]
    wire ssEnNew = (wrCtrl && !busy_q) ? regWrData[`RTC_B_SSEN] : ssEn_q; // [R23]
    wire todEnNew = (wrCtrl && !busy_q) ? regWrData[`RTC_B_TODEN] : todEn_q; // [R23]
    wire busySet = wrSecHi || wrSecLo || wrSub || (runNew != run_q) ||
                   (ssEnNew != ssEn_q) || (todEnNew != todEn_q); // [R8]

    wire todMatch = secUpd_q && (sec_q[19:0] == {almHi_q, almLo_q}); // [R3] [R17]
    wire ssReload = cntTick && ssEn_q && (ssTimer_q == {RELOAD_W{1'b0}});
    wire [5:0] trimSum = {1'b0, trimAcc_q} + {1'b0, trimMag_q};
    wire trimStep = secUpd_q && (sec_q[3:0] == `RTC_TRIM_PERIOD_MASK); // [R22]

    // Pin synchroniser
    always @(posedge mclk) begin
        if (!reset_n) begin
            oscS1_q <= 1'b0;
            oscS2_q <= 1'b0;
            oscS3_q <= 1'b0;
            oscLvl_q <= 1'b0;
        end else begin
            oscS1_q <= osc32kIn;
            oscS2_q <= oscS1_q;
            oscS3_q <= oscS2_q;
            if (oscS2_q == oscS3_q) begin
                oscLvl_q <= oscS3_q;
            end
        end
    end

    // Dividers and time base
    always @(posedge mclk) begin
        if (!reset_n) begin
            hfDiv_q <= 7'h00;
            presc_q <= 7'h00;
            subSec_q <= 8'h00;
            sec_q <= 32'h00000000;
            secUpd_q <= 1'b0;
            cntUpd_q <= 1'b0;
        end else begin
            hfDiv_q <= hfTick ? 7'h00 : hfDiv_q + 7'h01;
            if (srcTick) begin
                presc_q <= presc_q + 7'h01;
            end
            cntUpd_q <= cntTick;
            secUpd_q <= cntTick && (subSec_q == 8'hFF);
            if (cntTick) begin
                subSec_q <= subSec_q + 8'h01; // [R14] [R15]
                if (subSec_q == 8'hFF) begin
                    sec_q <= sec_q + 32'h00000001; // [R14] [R15]
                end
            end else begin
                if (wrSub) begin
                    subSec_q <= regWrData[7:0];
                end
                if (wrSecHi) begin
                    sec_q[31:16] <= regWrData;
                end
                if (wrSecLo) begin
                    sec_q[15:0] <= regWrData;
                end
            end
        end
    end

    // Trim accumulator
    always @(posedge mclk) begin
        if (!reset_n) begin
            trimDir_q <= 1'b0;
            trimMag_q <= 5'h00;
            trimAcc_q <= 5'h00;
            trimPend_q <= 1'b0;
        end else begin
            if (wrTrim) begin
                trimDir_q <= regWrData[`RTC_B_TRIMDIR]; // [R21]
                trimMag_q <= regWrData[`RTC_TRIMMAG_MSB:0];
            end
            if (trimStep) begin
                trimAcc_q <= trimSum[4:0]; // [R22]
            end
            if (trimStep && trimSum[5]) begin
                trimPend_q <= 1'b1; // [R22]
            end else if (trimUsed) begin
                trimPend_q <= 1'b0;
            end
        end
    end

    // Alarm registers and sub-second alarm timer
    always @(posedge mclk) begin
        if (!reset_n) begin
            almHi_q <= 4'h0;
            almLo_q <= `RTC_RST_ZERO16;
            reload_q <= {RELOAD_W{1'b0}};
            ssTimer_q <= {RELOAD_W{1'b0}};
        end else begin
            if (wrAlmHi) begin
                almHi_q <= regWrData[3:0];
            end
            if (wrAlmLo) begin
                almLo_q <= regWrData;
            end
            if (wrReload) begin
                reload_q <= regWrData[RELOAD_W-1:0];
            end
            if (!ssEn_q || ssReload) begin
                ssTimer_q <= reload_q; // [R19]
            end else if (cntTick) begin
                ssTimer_q <= ssTimer_q - {{(RELOAD_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Control and status register
    always @(posedge mclk) begin
        if (!reset_n) begin
            unlock_q <= 1'b0;
            oscDisable <= `RTC_RST_OSCDIS;
            altSrc_q <= 1'b0;
            sqRate_q <= 1'b0;
            sqEn_q <= 1'b0;
            ssFlag_q <= 1'b0;
            todFlag_q <= 1'b0;
            rdyIe_q <= 1'b0;
            rdy_q <= 1'b0;
            busy_q <= `RTC_RST_BUSY; // [R8]
            ssEn_q <= 1'b0;
            todEn_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            run_q <= runNew;
            ssEn_q <= ssEnNew;
            todEn_q <= todEnNew;
            if (wrCtrl) begin
                unlock_q <= regWrData[`RTC_B_UNLOCK];
                oscDisable <= regWrData[`RTC_B_OSCDIS];
                sqRate_q <= regWrData[`RTC_B_SQRATE];
                sqEn_q <= regWrData[`RTC_B_SQEN];
                rdyIe_q <= regWrData[`RTC_B_RDYIE];
                if (!run_q) begin
                    altSrc_q <= regWrData[`RTC_B_ALTSRC];
                end
            end
            // Hardware set wins over a software clear
            if (busySet) begin
                busy_q <= 1'b1; // [R8]
            end else if (srcTick) begin
                busy_q <= 1'b0; // [R8]
            end
            if (ssReload) begin
                ssFlag_q <= 1'b1; // [R19]
            end else if (wrCtrl && !regWrData[`RTC_B_SSFLAG]) begin
                ssFlag_q <= 1'b0;
            end
            if (todMatch) begin
                todFlag_q <= 1'b1; // [R3]
            end else if (wrCtrl && !regWrData[`RTC_B_TODFLAG]) begin
                todFlag_q <= 1'b0;
            end
            if (cntUpd_q) begin
                rdy_q <= 1'b1; // [R6]
            end else if (srcTick && run_q && (presc_q == `RTC_PRESC_PRERIPPLE)) begin
                rdy_q <= 1'b0; // [R7]
            end else if (wrCtrl && !regWrData[`RTC_B_RDY]) begin
                rdy_q <= 1'b0; // [R6]
            end
        end
    end

    // Requests and square-wave pin
    always @(posedge mclk) begin
        if (!reset_n) begin
            irqReq <= 1'b0;
            wakeReq <= 1'b0;
            sqWaveOut <= 1'b0;
            sqWaveOe_n <= 1'b1;
        end else begin
            irqReq <= (ssFlag_q && ssEn_q) || // [R10]
                      (todFlag_q && todEn_q) || // [R3] [R11]
                      (rdy_q && rdyIe_q); // [R5]
            wakeReq <= todFlag_q && todEn_q; // [R4]
            sqWaveOut <= sqEn_q && (sqRate_q ? presc_q[`RTC_TAP512_BIT] :
                                               subSec_q[`RTC_TAP1HZ_BIT]); // [R1]
            sqWaveOe_n <= !sqEn_q; // [R2]
        end
    end

    // Register reads, data valid in the following cycle only
    always @(posedge mclk) begin
        if (!reset_n) begin
            regRdData <= `RTC_RST_ZERO16;
        end else if (!regRd) begin
            regRdData <= `RTC_RST_ZERO16;
        end else if (regAddr == `RTC_ADDR_CTRL) begin
            regRdData <= {unlock_q, oscDisable, altSrc_q, 3'b000, sqRate_q, sqEn_q,
                          ssFlag_q, todFlag_q, rdyIe_q, rdy_q, busy_q, ssEn_q,
                          todEn_q, run_q};
        end else if (regAddr == `RTC_ADDR_SECHI) begin
            regRdData <= sec_q[31:16];
        end else if (regAddr == `RTC_ADDR_SECLO) begin
            regRdData <= sec_q[15:0];
        end else if (regAddr == `RTC_ADDR_SUBSEC) begin
            regRdData <= {8'h00, subSec_q};
        end else if (regAddr == `RTC_ADDR_ALMHI) begin
            regRdData <= {12'h000, almHi_q};
        end else if (regAddr == `RTC_ADDR_ALMLO) begin
            regRdData <= almLo_q;
        end else if (regAddr == `RTC_ADDR_RELOAD) begin
            regRdData <= reloadRd;
        end else begin
            regRdData <= {10'h000, trimDir_q, trimMag_q};
        end
    end

endmodule // rtc_counter_alarm_trim

`default_nettype wire

// [core/rtc_defines.vh]
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// Register word addresses
`define RTC_ADDR_CTRL 3'h0
`define RTC_ADDR_SECHI 3'h1
`define RTC_ADDR_SECLO 3'h2
`define RTC_ADDR_SUBSEC 3'h3
`define RTC_ADDR_ALMHI 3'h4
`define RTC_ADDR_ALMLO 3'h5
`define RTC_ADDR_RELOAD 3'h6
`define RTC_ADDR_TRIM 3'h7

// Control and status bit positions
`define RTC_B_UNLOCK 15
`define RTC_B_OSCDIS 14
`define RTC_B_ALTSRC 13
`define RTC_B_SQRATE 9
`define RTC_B_SQEN 8
`define RTC_B_SSFLAG 7
`define RTC_B_TODFLAG 6
`define RTC_B_RDYIE 5
`define RTC_B_RDY 4
`define RTC_B_BUSY 3
`define RTC_B_SSEN 2
`define RTC_B_TODEN 1
`define RTC_B_RUN 0

// Trim fields
`define RTC_B_TRIMDIR 5
`define RTC_TRIMMAG_MSB 4

// Reset values
`define RTC_RST_OSCDIS 1'b1
`define RTC_RST_BUSY 1'b1
`define RTC_RST_ZERO16 16'h0000

// Divider figures: prescaler counts in input clock cycles, tap bit numbers, trim period mask
`define RTC_PRESC_LAST 7'h7F
`define RTC_PRESC_PRERIPPLE 7'h7E
`define RTC_PRESC_HALF 7'h3F
`define RTC_TAP512_BIT 5
`define RTC_TAP1HZ_BIT 7
`define RTC_TRIM_PERIOD_MASK 4'h0

`endif

// [verif/rtc_cat_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.vh"
module rtc_cat_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    // Pins and requests
    input wire logic osc32kIn,
    input wire logic sqWaveOut,
    input wire logic sqWaveOe_n,
    input wire logic irqReq,
    input wire logic wakeReq,
    input wire logic oscDisable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_wave_off_low: assert property (sqWaveOe_n |-> !sqWaveOut)
        else $error("square wave data while pin released");
    a_oe_quiet: assert property (!$past(regWr) && !$past(regWr, 2) |-> $stable(sqWaveOe_n))
        else $error("pin enable moved without a write");
    a_oe_matches_bit: assert property ($past(regRd && regAddr == `RTC_ADDR_CTRL)
        |-> regRdData[8] == !sqWaveOe_n)
        else $error("pin enable differs from enable bit");
    a_wake_has_irq: assert property (wakeReq |-> irqReq)
        else $error("wakeup without interrupt request");
    a_wake_needs_en: assert property ($past(regRd && regAddr == `RTC_ADDR_CTRL)
        && !regRdData[1] |-> !wakeReq)
        else $error("wakeup with day alarm disabled");
    a_alarm_hi_width: assert property ($past(regRd && regAddr == `RTC_ADDR_ALMHI)
        |-> regRdData[15:4] == 12'h000)
        else $error("alarm upper holds more than four bits");
    a_subsec_width: assert property ($past(regRd && regAddr == `RTC_ADDR_SUBSEC)
        |-> regRdData[15:8] == 8'h00)
        else $error("sub-second count wider than eight bits");
    a_trim_width: assert property ($past(regRd && regAddr == `RTC_ADDR_TRIM)
        |-> regRdData[15:6] == 10'h000)
        else $error("trim reserved bits not zero");
endmodule // rtc_cat_asserts
`default_nettype wire

// [verif/rtc_counter_alarm_trim_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.vh"
module rtc_counter_alarm_trim_tb_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic osc32kIn = 1'b0;
    logic oscRun = 1'b0;
    logic [15:0] regRdData;
    logic sqWaveOut, sqWaveOe_n, irqReq, wakeReq, oscDisable;
    logic [15:0] rd;
    logic [15:0] keep;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    rtc_counter_alarm_trim DUT (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .osc32kIn(osc32kIn), .sqWaveOut(sqWaveOut), .sqWaveOe_n(sqWaveOe_n),
        .irqReq(irqReq), .wakeReq(wakeReq), .oscDisable(oscDisable));
    initial forever #20 mclk = ~mclk;
    // Slow clock: 8 mclk period, held still when oscRun is low
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (oscRun && cyc % 4 == 3)
            osc32kIn <= ~osc32kIn;
        if (cyc == 30000) begin
            fails = fails + 1;
            $display("MISMATCH %0t timeout", $time);
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rdr(input logic [2:0] a);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rd = regRdData;
    endtask
    // Polls one control bit until it reaches v, bounded
    task automatic waitbit(input int b, input logic v);
        int k;
        k = 0;
        rdr(`RTC_ADDR_CTRL);
        while (rd[b] !== v && k < 2500) begin
            rdr(`RTC_ADDR_CTRL);
            k++;
        end
        chk({15'h0, rd[b]}, {15'h0, v});
    endtask
    task automatic edges;
        logic last;
        n = 0;
        last = sqWaveOut;
        repeat (600) begin
            @(negedge mclk);
            if (sqWaveOut !== last) n++;
            last = sqWaveOut;
        end
    endtask
    task automatic t_reset;
        rdr(`RTC_ADDR_CTRL);
        chk(rd, 16'h4008);
        for (int a = 1; a < 8; a++) begin
            rdr(a[2:0]);
            chk(rd, 16'h0000);
        end
        chk({11'h0, oscDisable, sqWaveOe_n, sqWaveOut, irqReq, wakeReq}, 16'h0018);
        oscRun <= 1'b1;
        waitbit(3, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_lock;
        wr(`RTC_ADDR_TRIM, 16'h0025);
        rdr(`RTC_ADDR_TRIM);
        chk(rd, 16'h0000);
        wr(`RTC_ADDR_CTRL, 16'h0001);
        rdr(`RTC_ADDR_CTRL);
        chk(rd, 16'h0000);
        wr(`RTC_ADDR_CTRL, 16'h8000);
        wr(`RTC_ADDR_TRIM, 16'h00E5);
        rdr(`RTC_ADDR_TRIM);
        chk(rd, 16'h0025);
        oscRun <= 1'b0;
        // Let a pin edge already in the synchroniser drain before testing busy
        repeat (8) @(posedge mclk);
        wr(`RTC_ADDR_CTRL, 16'h8001);
        wr(`RTC_ADDR_CTRL, 16'h8000);
        rdr(`RTC_ADDR_CTRL);
        chk(rd, 16'h8009);
        oscRun <= 1'b1;
        waitbit(3, 1'b0);
        $display("test lock done");
    endtask
    task automatic t_count;
        wr(`RTC_ADDR_SECLO, 16'h1234);
        rdr(`RTC_ADDR_SECLO);
        chk(rd, 16'h0000);
        wr(`RTC_ADDR_CTRL, 16'h8000);
        waitbit(3, 1'b0);
        rdr(`RTC_ADDR_SUBSEC);
        keep = rd;
        repeat (1100) @(posedge mclk);
        rdr(`RTC_ADDR_SUBSEC);
        chk(rd, keep);
        wr(`RTC_ADDR_SECHI, 16'h0001);
        waitbit(3, 1'b0);
        wr(`RTC_ADDR_SECLO, 16'h0004);
        waitbit(3, 1'b0);
        wr(`RTC_ADDR_SUBSEC, 16'h00FF);
        waitbit(3, 1'b0);
        wr(`RTC_ADDR_ALMHI, 16'h00F1);
        wr(`RTC_ADDR_ALMLO, 16'h0005);
        rdr(`RTC_ADDR_ALMHI);
        chk(rd, 16'h0001);
        wr(`RTC_ADDR_CTRL, 16'h8003);
        waitbit(6, 1'b1);
        chk({14'h0, irqReq, wakeReq}, 16'h0003);
        rdr(`RTC_ADDR_SECLO);
        chk(rd, 16'h0005);
        rdr(`RTC_ADDR_SECHI);
        chk(rd, 16'h0001);
        wr(`RTC_ADDR_CTRL, 16'h8041);
        waitbit(3, 1'b0);
        chk(rd & 16'h00C7, 16'h0041);
        chk({14'h0, irqReq, wakeReq}, 16'h0000);
        $display("test count done");
    endtask
    task automatic t_ready;
        wr(`RTC_ADDR_CTRL, 16'h8061);
        waitbit(4, 1'b1);
        waitbit(4, 1'b0);
        waitbit(4, 1'b1);
        chk({15'h0, irqReq}, 16'h0001);
        wr(`RTC_ADDR_CTRL, 16'h8061);
        rdr(`RTC_ADDR_CTRL);
        chk({15'h0, rd[4] | irqReq}, 16'h0000);
        wr(`RTC_ADDR_CTRL, 16'h8041);
        waitbit(4, 1'b1);
        chk({15'h0, irqReq}, 16'h0000);
        $display("test ready done");
    endtask
    task automatic t_sqw;
        wr(`RTC_ADDR_CTRL, 16'h8341);
        repeat (3) @(posedge mclk);
        chk({15'h0, sqWaveOe_n}, 16'h0000);
        edges();
        chk({15'h0, n > 1}, 16'h0001);
        wr(`RTC_ADDR_CTRL, 16'h8141);
        edges();
        chk(16'(n), 16'h0000);
        wr(`RTC_ADDR_CTRL, 16'h8041);
        repeat (3) @(posedge mclk);
        chk({14'h0, sqWaveOe_n, sqWaveOut}, 16'h0002);
        $display("test square wave done");
    endtask
    task automatic t_subsec;
        wr(`RTC_ADDR_RELOAD, 16'h0002);
        wr(`RTC_ADDR_CTRL, 16'h8045);
        waitbit(3, 1'b0);
        wr(`RTC_ADDR_RELOAD, 16'h0009);
        rdr(`RTC_ADDR_RELOAD);
        chk(rd, 16'h0002);
        waitbit(7, 1'b1);
        chk({15'h0, irqReq}, 16'h0001);
        wr(`RTC_ADDR_CTRL, 16'h80C1);
        waitbit(3, 1'b0);
        chk({15'h0, irqReq}, 16'h0000);
        $display("test sub-second done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_lock();
        t_count();
        t_ready();
        t_sqw();
        t_subsec();
        wrap_up();
    end
endmodule // rtc_counter_alarm_trim_tb_top
bind rtc_counter_alarm_trim rtc_cat_asserts u_chk (.mclk(mclk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .osc32kIn(osc32kIn), .sqWaveOut(sqWaveOut),
    .sqWaveOe_n(sqWaveOe_n), .irqReq(irqReq), .wakeReq(wakeReq), .oscDisable(oscDisable));
`default_nettype wire
